// *** shared/iovf_defines.vh ***
// Constants of the output value formatter
`ifndef IOVF_DEFINES_VH
`define IOVF_DEFINES_VH
`define IOVF_W24        24
`define IOVF_W16        16
`define IOVF_ACC_W      40
`define IOVF_CNT_W      16
`define IOVF_MODE_ACC   3'h0
`define IOVF_MODE_AVG   3'h1
`define IOVF_MODE_IVEL  3'h2
`define IOVF_MODE_INTV  3'h3
`define IOVF_MODE_TEMP  3'h4
`define IOVF_MODE_AUX   3'h5
`define IOVF_RNG_2G     3'h0
`define IOVF_RNG_5G     3'h1
`define IOVF_RNG_10G    3'h2
`define IOVF_RNG_30G    3'h3
`define IOVF_RNG_80G    3'h4
`define IOVF_RNG_INCL   3'h5
`define IOVF_FIFO_DEPTH 16
`define IOVF_FIFO_AW    4
`define IOVF_WRAP_MASK     24'h7FFFFF
`define IOVF_WRAP_MASK_80G 24'h3FFFFF
`define IOVF_WRAP_TOP      5'h17
`define IOVF_WRAP_TOP_80G  5'h16
`define IOVF_DIV_STEPS     6'h27
`define IOVF_LAST_B16      2'h1
`define IOVF_LAST_B24      2'h2
`endif

// *** testbench/iovf_checker.sv ***
// Port assertions of the output value formatter
`timescale 1ns/1ns
`include "iovf_defines.vh"
module iovf_checker (
  input wire        clk_sys,
  input wire        reset,
  input wire [2:0]  out_mode,
  input wire [2:0]  out_range,
  input wire        sample_valid,
  input wire        send_req,
  input wire        send_ready,
  input wire [7:0]  byte_data,
  input wire        byte_valid,
  input wire        byte_ready,
  input wire        send_busy
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  wire take = send_req && send_ready;
  wire avg  = out_mode == `IOVF_MODE_AVG;
  property p_rst_v; disable iff (1'b0) reset |=> !byte_valid; endproperty
  a_rst_v: assert property (p_rst_v) else $error("valid after reset");
  property p_rst_b; disable iff (1'b0) reset |=> !send_busy; endproperty
  a_rst_b: assert property (p_rst_b) else $error("busy after reset");
  property p_hold;
    byte_valid && !byte_ready |=> byte_valid && $stable(byte_data);
  endproperty
  a_hold: assert property (p_hold) else $error("byte not held");
  property p_refuse; send_busy |-> !send_ready; endproperty
  a_refuse: assert property (p_refuse) else $error("ready while busy");
  property p_first; take && !byte_valid && !avg |-> ##2 byte_valid; endproperty
  a_first: assert property (p_first) else $error("first byte late");
  property p_avg; take && avg && !byte_valid |=> !byte_valid [*8]; endproperty
  a_avg: assert property (p_avg) else $error("mean too early");
  property p_end; take |-> ##[1:300] send_ready; endproperty
  a_end: assert property (p_end) else $error("field never ends");
  property p_busy; take |=> send_busy; endproperty
  a_busy: assert property (p_busy) else $error("request not taken");
endmodule
bind iovf_formatter iovf_checker chk (.clk_sys(clk_sys), .reset(reset),
  .out_mode(out_mode), .out_range(out_range), .sample_valid(sample_valid),
  .send_req(send_req), .send_ready(send_ready), .byte_data(byte_data),
  .byte_valid(byte_valid), .byte_ready(byte_ready), .send_busy(send_busy));

// *** testbench/iovf_host_model.sv ***
// Host model collecting the formatted bytes
`timescale 1ns/1ns
module iovf_host_model (
  input  wire       clk_sys,
  input  wire       reset,
  input  wire       stall,
  input  wire [7:0] byte_data,
  input  wire       byte_valid,
  output reg        byte_ready
);
  logic [7:0] q[$];
  initial byte_ready = 1'b0;
  always @(posedge clk_sys) begin
    if (byte_valid && byte_ready && !reset)
      q.push_back(byte_data);
    byte_ready <= !stall && !reset;
  end
endmodule

// *** testbench/tb_iovf_formatter.sv ***
// Self-checking testbench of the output value formatter
`timescale 1ns/1ns
`include "iovf_defines.vh"
module tb_iovf_formatter;
  reg        clk_sys = 1'b0;
  reg        reset = 1'b1;
  reg [2:0]  out_mode = 3'h0;
  reg [2:0]  out_range = 3'h0;
  reg        sample_valid = 1'b0;
  reg [23:0] s_val = 24'h0;
  reg        send_req = 1'b0;
  reg        stall = 1'b0;
  wire       send_ready;
  wire [7:0] byte_data;
  wire       byte_valid;
  wire       byte_ready;
  wire       send_busy;
  integer    errors = 0;
  integer    num_checks = 0;
  always #20 clk_sys = ~clk_sys;
  iovf_formatter dut (.clk_sys(clk_sys), .reset(reset), .out_mode(out_mode),
    .out_range(out_range), .sample_valid(sample_valid),
    .sample_accel(s_val), .sample_dvel(s_val), .sample_temp(s_val[15:0]),
    .sample_aux(s_val), .send_req(send_req), .send_ready(send_ready),
    .byte_data(byte_data), .byte_valid(byte_valid),
    .byte_ready(byte_ready), .send_busy(send_busy));
  iovf_host_model host (.clk_sys(clk_sys), .reset(reset), .stall(stall),
    .byte_data(byte_data), .byte_valid(byte_valid), .byte_ready(byte_ready));
  task give_verdict;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk(input [23:0] got, input [23:0] exp);
    num_checks = num_checks + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task rst;
    @(posedge clk_sys);
    reset <= 1'b1;
    repeat (4) @(posedge clk_sys);
    reset <= 1'b0;
  endtask
  task smp(input [23:0] v);
    @(posedge clk_sys);
    s_val <= v;
    sample_valid <= 1'b1;
    @(posedge clk_sys);
    sample_valid <= 1'b0;
  endtask
  task req(input [2:0] m, input [2:0] r);
    integer i;
    i = 0;
    @(negedge clk_sys);
    while (send_ready !== 1'b1 && i < 400) begin
      @(negedge clk_sys);
      i = i + 1;
    end
    if (i == 400) begin
      chk(24'h1, 24'h0);
      give_verdict;
    end
    @(posedge clk_sys);
    out_mode <= m;
    out_range <= r;
    send_req <= 1'b1;
    @(posedge clk_sys);
    send_req <= 1'b0;
  endtask
  task rx(input [23:0] v, input integer n);
    integer i;
    for (i = 0; i < 400 && host.q.size() < n; i = i + 1) @(negedge clk_sys);
    if (host.q.size() < n) begin
      chk(24'h1, 24'h0);
      give_verdict;
    end
    for (i = n - 1; i >= 0; i = i - 1) chk(host.q.pop_front(), v[8*i +: 8]);
  endtask
  task s_fields;
    integer k;
    for (k = 0; k < 6; k = k + 1) begin
      smp(24'h123456 + k);
      req(`IOVF_MODE_ACC, k);
      rx(24'h123456 + k, 3);
    end
    smp(24'h80ABCD);
    req(`IOVF_MODE_IVEL, `IOVF_RNG_INCL);
    rx(24'h80ABCD, 3);
    smp(24'h800001);
    req(`IOVF_MODE_AUX, `IOVF_RNG_2G);
    rx(24'h800001, 3);
    smp(24'h00F380);
    req(`IOVF_MODE_TEMP, `IOVF_RNG_2G);
    rx(24'h00F380, 2);
    repeat (8) @(negedge clk_sys);
    chk(host.q.size(), 24'h0);
  endtask
  task s_avg;
    smp(24'hFFFFF0);
    smp(24'h000020);
    smp(24'h000010);
    smp(24'h000004);
    req(`IOVF_MODE_AVG, `IOVF_RNG_10G);
    rx(24'h000009, 3);
    req(`IOVF_MODE_AVG, `IOVF_RNG_10G);
    rx(24'h000000, 3);
  endtask
  task s_intv;
    rst;
    smp(24'h7FFFFF);
    smp(24'h000002);
    req(`IOVF_MODE_INTV, `IOVF_RNG_INCL);
    rx(24'h800001, 3);
    smp(24'h000001);
    req(`IOVF_MODE_INTV, `IOVF_RNG_2G);
    rx(24'h800002, 3);
    @(posedge clk_sys);
    out_range <= `IOVF_RNG_80G;
    rst;
    smp(24'h3FFFFF);
    smp(24'h000001);
    req(`IOVF_MODE_INTV, `IOVF_RNG_80G);
    rx(24'hC00000, 3);
  endtask
  task s_fifo;
    integer k;
    @(posedge clk_sys);
    stall <= 1'b1;
    smp(24'hA5C3E1);
    for (k = 0; k < 6; k = k + 1) req(`IOVF_MODE_ACC, `IOVF_RNG_30G);
    repeat (10) @(negedge clk_sys);
    chk(byte_valid, 24'h1);
    chk(send_ready, 24'h0);
    @(posedge clk_sys);
    stall <= 1'b0;
    for (k = 0; k < 6; k = k + 1) rx(24'hA5C3E1, 3);
  endtask
  initial begin
    rst;
    s_fields;
    s_avg;
    s_intv;
    s_fifo;
    give_verdict;
  end
endmodule

// *** verilog/iovf_fifo.v ***
// Byte FIFO between formatter and datagram assembler
`timescale 1ns/1ns
module iovf_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             clk_sys,
  input  wire             reset,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  output reg  [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_ff;
  reg [AW-1:0]    rd_ptr_ff;
  reg [AW:0]      count_ff;
  wire            push;
  wire            pop;

  localparam [AW:0] FULL_COUNT = DEPTH;

  assign in_ready  = (count_ff != FULL_COUNT);
  assign out_valid = (count_ff != {(AW+1){1'b0}});
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always @* begin
    out_data = mem[rd_ptr_ff];
  end

  always @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr_ff] <= in_data;
    end
  end

  always @(posedge clk_sys) begin
    if (reset) begin
      wr_ptr_ff <= {AW{1'b0}};
      rd_ptr_ff <= {AW{1'b0}};
      count_ff  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
      if (push && !pop) begin
        count_ff <= count_ff + 1'b1;
      end else if (pop && !push) begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end
endmodule

// *** verilog/iovf_formatter.v ***
// Measurement field formatter with averaging and velocity integration
// How it works
// - Averaged output is mean since last transmission
// - At 500Hz, mean of preceding four samples
// - Integrated velocity accumulates from reset, never cleared
// - Integrated velocity wraps silently, no error flag
// - Wrap interval half-open, set by g-range
// - Integrated velocity scaled like incremental velocity
// - Averaged acceleration scaled like plain acceleration
// - 24-bit fields sent MSB, middle, LSB
// - Inclinometer acceleration 2^22 counts per g
// - Inclinometer velocity increment 2^25 counts per m/s
// - Inclinometer integral wraps within plus/minus 0.25
// - Temperature 16 bits, 2^8 counts per degree
// - Auxiliary sample sent as 24-bit field
// - Auxiliary full 2^24 span equals 5V
// - Accelerometer acceleration scaled per range
// - Accelerometer velocity increment scaled per range
`timescale 1ns/1ns
`include "iovf_defines.vh"
module iovf_formatter #(
  parameter FIFO_DEPTH = `IOVF_FIFO_DEPTH,
  parameter FIFO_AW    = `IOVF_FIFO_AW,
  parameter MAX_DIV    = 16
) (
  input  wire        clk_sys,
  input  wire        reset,
  input  wire [2:0]  out_mode,
  input  wire [2:0]  out_range,
  input  wire        sample_valid,
  input  wire [23:0] sample_accel,
  input  wire [23:0] sample_dvel,
  input  wire [15:0] sample_temp,
  input  wire [23:0] sample_aux,
  input  wire        send_req,
  output wire        send_ready,
  output wire [7:0]  byte_data,
  output wire        byte_valid,
  input  wire        byte_ready,
  output wire        send_busy
);
  localparam ST_IDLE = 4'h1;
  localparam ST_DIV  = 4'h2;
  localparam ST_EMIT = 4'h4;
  localparam ST_DONE = 4'h8;

  reg  [3:0]  state_ff;
  reg  [3:0]  nxt_state;
  reg  [39:0] avg_sum_ff;
  reg  [39:0] nxt_avg_sum;
  reg  [15:0] avg_cnt_ff;
  reg  [15:0] nxt_avg_cnt;
  reg  [23:0] intv_ff;
  reg  [23:0] nxt_intv;
  reg  [39:0] quot_ff;
  reg  [39:0] nxt_quot;
  reg  [39:0] rem_ff;
  reg  [39:0] nxt_rem;
  reg  [5:0]  div_bit_ff;
  reg  [5:0]  nxt_div_bit;
  reg  [39:0] div_num_ff;
  reg  [39:0] nxt_div_num;
  reg  [15:0] div_den_ff;
  reg  [15:0] nxt_div_den;
  reg         div_neg_ff;
  reg         nxt_div_neg;
  reg  [23:0] field_ff;
  reg  [23:0] nxt_field;
  reg  [1:0]  byte_idx_ff;
  reg  [1:0]  nxt_byte_idx;
  reg  [1:0]  byte_last_ff;
  reg  [1:0]  nxt_byte_last;
  reg  [7:0]  push_byte;
  reg  [23:0] wrap_mask;
  reg         wrap_sign;
  reg  [39:0] sum_abs;
  reg  [40:0] rem_shift;
  reg  [23:0] mean_mag;
  reg  [23:0] req_field;
  wire        fifo_in_ready;
  wire        push_valid;
  wire        push_last;
  wire        div_fit;
  wire        div_end;
  wire [39:0] accel_ext;
  wire [23:0] intv_sum;
  wire        avg_take;
  wire [7:0]  lane_byte [0:2];

  assign accel_ext  = {{16{sample_accel[23]}}, sample_accel};
  assign send_ready = (state_ff == ST_IDLE);
  assign send_busy  = (state_ff != ST_IDLE);
  assign push_valid = (state_ff == ST_EMIT);
  assign push_last  = push_valid && fifo_in_ready &&
                      (byte_idx_ff == byte_last_ff);
  assign avg_take   = send_req && (state_ff == ST_IDLE);
  assign intv_sum   = intv_ff + sample_dvel;
  assign div_fit    = (rem_shift >= {25'h0000000, div_den_ff});
  assign div_end    = (state_ff == ST_DIV) && (div_bit_ff == 6'h00);

  // Keep the interval's low bits and repeat its sign bit above them
  always @* begin
    case (out_range)
      `IOVF_RNG_2G: begin
        wrap_mask = `IOVF_WRAP_MASK;
        wrap_sign = intv_sum[`IOVF_WRAP_TOP];
      end
      `IOVF_RNG_5G: begin
        wrap_mask = `IOVF_WRAP_MASK;
        wrap_sign = intv_sum[`IOVF_WRAP_TOP];
      end
      `IOVF_RNG_10G: begin
        wrap_mask = `IOVF_WRAP_MASK;
        wrap_sign = intv_sum[`IOVF_WRAP_TOP];
      end
      `IOVF_RNG_30G: begin
        wrap_mask = `IOVF_WRAP_MASK;
        wrap_sign = intv_sum[`IOVF_WRAP_TOP];
      end
      `IOVF_RNG_80G: begin
        wrap_mask = `IOVF_WRAP_MASK_80G;
        wrap_sign = intv_sum[`IOVF_WRAP_TOP_80G];
      end
      `IOVF_RNG_INCL: begin
        wrap_mask = `IOVF_WRAP_MASK;
        wrap_sign = intv_sum[`IOVF_WRAP_TOP];
      end
      default: begin
        wrap_mask = `IOVF_WRAP_MASK;
        wrap_sign = intv_sum[`IOVF_WRAP_TOP];
      end
    endcase
  end

  // Silent wrap: no error flag exists for it
  always @* begin
    nxt_intv = (intv_sum & wrap_mask) |
               ({24{wrap_sign}} & ~wrap_mask);
  end

  // Integrator runs on every sample, cleared only by reset
  always @(posedge clk_sys) begin
    if (reset) begin
      intv_ff <= 24'h000000;
    end else if (sample_valid) begin
      intv_ff <= nxt_intv;
    end
  end

  // Averager sums samples since last send, restarts on the send
  always @* begin
    nxt_avg_sum = avg_sum_ff;
    nxt_avg_cnt = avg_cnt_ff;
    if (avg_take) begin
      nxt_avg_sum = sample_valid ? accel_ext : 40'h0000000000;
      nxt_avg_cnt = sample_valid ? 16'h0001 : 16'h0000;
    end else if (sample_valid) begin
      nxt_avg_sum = avg_sum_ff + accel_ext;
      if (avg_cnt_ff != 16'hFFFF) begin
        nxt_avg_cnt = avg_cnt_ff + 16'h0001;
      end
    end
  end

  always @(posedge clk_sys) begin
    if (reset) begin
      avg_sum_ff <= 40'h0000000000;
      avg_cnt_ff <= 16'h0000;
    end else begin
      avg_sum_ff <= nxt_avg_sum;
      avg_cnt_ff <= nxt_avg_cnt;
    end
  end

  always @* begin
    sum_abs   = avg_sum_ff[39] ? (40'h0000000000 - avg_sum_ff) : avg_sum_ff;
    rem_shift = {rem_ff, div_num_ff[39]};
  end

  // One restoring divide step per cycle on the magnitude of the sum
  always @* begin
    nxt_div_num = div_num_ff;
    nxt_div_den = div_den_ff;
    nxt_div_neg = div_neg_ff;
    nxt_div_bit = div_bit_ff;
    nxt_quot    = quot_ff;
    nxt_rem     = rem_ff;
    mean_mag    = {quot_ff[22:0], div_fit};
    case (state_ff)
      ST_IDLE: begin
        if (send_req) begin
          nxt_div_num = sum_abs;
          nxt_div_neg = avg_sum_ff[39];
          nxt_div_den = (avg_cnt_ff == 16'h0000) ? 16'h0001 : avg_cnt_ff;
          nxt_quot    = 40'h0000000000;
          nxt_rem     = 40'h0000000000;
          nxt_div_bit = `IOVF_DIV_STEPS;
        end
      end
      ST_DIV: begin
        nxt_div_num = {div_num_ff[38:0], 1'b0};
        nxt_div_bit = div_bit_ff - 6'h01;
        if (div_fit) begin
          nxt_rem  = rem_shift[39:0] - {24'h000000, div_den_ff};
          nxt_quot = {quot_ff[38:0], 1'b1};
        end else begin
          nxt_rem  = rem_shift[39:0];
          nxt_quot = {quot_ff[38:0], 1'b0};
        end
      end
      default: begin
        nxt_div_bit = div_bit_ff;
      end
    endcase
  end

  always @(posedge clk_sys) begin
    if (reset) begin
      quot_ff    <= 40'h0000000000;
      rem_ff     <= 40'h0000000000;
      div_bit_ff <= 6'h00;
      div_num_ff <= 40'h0000000000;
      div_den_ff <= 16'h0001;
      div_neg_ff <= 1'b0;
    end else begin
      quot_ff    <= nxt_quot;
      rem_ff     <= nxt_rem;
      div_bit_ff <= nxt_div_bit;
      div_num_ff <= nxt_div_num;
      div_den_ff <= nxt_div_den;
      div_neg_ff <= nxt_div_neg;
    end
  end

  // Field picked at the request, already scaled by the sensor path
  always @* begin
    case (out_mode)
      `IOVF_MODE_ACC:  req_field = sample_accel;
      `IOVF_MODE_IVEL: req_field = sample_dvel;
      `IOVF_MODE_INTV: req_field = intv_ff;
      `IOVF_MODE_TEMP: req_field = {sample_temp, 8'h00};
      `IOVF_MODE_AUX:  req_field = sample_aux;
      default:         req_field = 24'h000000;
    endcase
  end

  // Mean keeps the plain acceleration scaling
  always @* begin
    nxt_field = field_ff;
    if (avg_take) begin
      nxt_field = req_field;
    end else if (div_end) begin
      nxt_field = div_neg_ff ? (24'h000000 - mean_mag) :
                  mean_mag;
    end
  end

  // Byte index walks the field, temperature has two bytes
  always @* begin
    nxt_byte_idx  = byte_idx_ff;
    nxt_byte_last = byte_last_ff;
    case (state_ff)
      ST_IDLE: begin
        nxt_byte_idx  = 2'h0;
        nxt_byte_last = (out_mode == `IOVF_MODE_TEMP) ? `IOVF_LAST_B16 :
                        `IOVF_LAST_B24;
      end
      ST_EMIT: begin
        if (fifo_in_ready) begin
          nxt_byte_idx = byte_idx_ff + 2'h1;
        end
      end
      default: begin
        nxt_byte_idx = byte_idx_ff;
      end
    endcase
  end

  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (send_req) begin
          nxt_state = (out_mode == `IOVF_MODE_AVG) ? ST_DIV : ST_EMIT;
        end
      end
      ST_DIV: begin
        if (div_end) begin
          nxt_state = ST_EMIT;
        end
      end
      ST_EMIT: begin
        if (push_last) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_DONE: nxt_state = ST_IDLE;
      default: nxt_state = ST_IDLE;
    endcase
  end

  // State, byte sequencing and the held field
  always @(posedge clk_sys) begin
    if (reset) begin
      state_ff     <= ST_IDLE;
      field_ff     <= 24'h000000;
      byte_idx_ff  <= 2'h0;
      byte_last_ff <= `IOVF_LAST_B24;
    end else begin
      state_ff     <= nxt_state;
      field_ff     <= nxt_field;
      byte_idx_ff  <= nxt_byte_idx;
      byte_last_ff <= nxt_byte_last;
    end
  end

  // One lane per byte of the field, most significant lane first
  genvar lane;
  generate
    for (lane = 0; lane < 3; lane = lane + 1) begin : g_lane
      assign lane_byte[lane] = field_ff[23-8*lane -: 8];
    end
  endgenerate

  always @* begin
    case (byte_idx_ff)
      2'h0:    push_byte = lane_byte[0];
      2'h1:    push_byte = lane_byte[1];
      2'h2:    push_byte = lane_byte[2];
      default: push_byte = 8'h00;
    endcase
  end

  iovf_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .in_data   (push_byte),
    .in_valid  (push_valid),
    .in_ready  (fifo_in_ready),
    .out_data  (byte_data),
    .out_valid (byte_valid),
    .out_ready (byte_ready)
  );
endmodule
